/* hdl/sar_ctl_pkg.sv */
// constants shared by the dual converter sequencing block
// assumes a single 50 MHz core clock plus a host serial clock for the read port
package sar_ctl_pkg;
  localparam int RES_BITS      = 14;
  localparam int FRAME_BITS    = 2 * RES_BITS;
  localparam int CORE_CLK_HZ   = 50_000_000;
  // time allowed for the dac and comparator to settle per decided bit
  localparam int SETTLE_NS     = 60;
  localparam int SETTLE_CYCLES = (SETTLE_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SYNC_MIN      = 3;  // comparator synchroniser lag plus one

  // wishbone register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;

  // status field positions
  localparam int ST_BUSY   = 0;
  localparam int ST_PDOWN  = 1;
  localparam int ST_REFINT = 2;
  localparam int ST_SPAN   = 3;   // two bits
  localparam int ST_PAIR   = 5;
  localparam int ST_BADSPN = 6;
  localparam int ST_HOLD   = 7;
  localparam int RES_B_LSB = 16;

  localparam logic [1:0] SPAN_PM10    = 2'b00;
  localparam logic [1:0] SPAN_PM5     = 2'b01;
  localparam logic [1:0] SPAN_UNI10   = 2'b10;
  localparam logic [1:0] SPAN_RESERVD = 2'b11;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {ST_TRACK, ST_CONVERT, ST_POWER_DOWN} conv_state_e;
endpackage

/* hdl/dual_sar_conversion_control.sv */
// dual 14-bit successive approximation sequencer with serial read-out
// assumes analog comparator and trigger pins are asynchronous to core_clk, and the
// serial read port runs on the host serial clock, stopped outside frames
module dual_sar_conversion_control
  import sar_ctl_pkg::*;
#(
  parameter int SETTLE_DEFAULT = SETTLE_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // host pins
  input  wire logic        conversion_trigger_n,
  input  wire logic        reference_source_select,
  input  wire logic        input_span_sel_lo,
  input  wire logic        input_span_sel_hi,
  input  wire logic        pair_select,
  output logic             busy,
  // serial read port, serial_clk is the host clock
  input  wire logic        serial_clk,
  input  wire logic        chip_select_n,
  output logic             result_out_first,
  output logic             result_out_first_oe,
  output logic             result_out_second,
  output logic             result_out_second_oe,
  // analog front end
  input  wire logic        comp_a,
  input  wire logic        comp_b,
  output logic [RES_BITS-1:0] dac_a,
  output logic [RES_BITS-1:0] dac_b,
  output logic             hold,
  output logic             analog_power_down,
  output logic             pair_mux_sel,
  output logic             ref_internal,
  output logic [1:0]       span_code
);

  initial begin
    if (SETTLE_DEFAULT < SYNC_MIN || SETTLE_DEFAULT > 255)
      $error("settle count out of range");
  end

  // two-flop synchronisers for every asynchronous pin into the core domain
  // every pin, the comparators included, costs two core cycles of lag; the
  // settle count floor is sized so a decision always sees the settled answer
  // reset value 1 matches the idle level of the trigger and chip select, so
  // leaving reset never looks like a falling edge on either pin
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pin_raw = {chip_select_n, comp_b, comp_a, pair_select, input_span_sel_hi,
                    input_span_sel_lo, reference_source_select, conversion_trigger_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else if (ce) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire       trig_s   = sync2_q[0];
  wire       ref_s    = sync2_q[1];
  wire [1:0] span_s   = sync2_q[3:2];
  wire       pair_s   = sync2_q[4];
  wire       cmp_a_s  = sync2_q[5];
  wire       cmp_b_s  = sync2_q[6];
  wire       cs_n_s   = sync2_q[7];

  // registers
  // the core holds the conversion, the finished codes and the static pin levels;
  // the serial domain below keeps only its bit counter and two output flops
  conv_state_e        state_q, state_d;
  logic               trig_prev_q;
  logic [7:0]         settle_cfg_q;
  logic [7:0]         settle_cnt_q;
  logic [3:0]         bit_q;
  logic [RES_BITS-1:0] sar_a_q, sar_b_q;
  logic [RES_BITS-1:0] res_a_q, res_b_q;   // codes as seen by the read port
  logic [RES_BITS-1:0] new_a_q, new_b_q;   // finished codes awaiting the port
  logic               new_pend_q;
  logic               pair_latch_q;
  logic               pair_mux_q;
  logic               ref_q;
  logic [1:0]         span_q;
  logic               bad_span_q;
  logic               ack_q;

  wire trig_fall = trig_prev_q & ~trig_s;
  wire trig_rise = ~trig_prev_q & trig_s;
  wire step_due  = (settle_cnt_q == 8'h00);
  wire last_bit  = (bit_q == 4'h0);
  wire conv_end  = (state_q == ST_CONVERT) && step_due && last_bit;
  wire conv_go   = (state_q == ST_TRACK) && trig_fall;

  // trial bit for the current step and the next lower one
  // both converters share one bit index because they start and step together,
  // which is what keeps the two samples simultaneous
  function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = {{(RES_BITS-1){1'b0}}, 1'b1} << idx;
  endfunction

  wire [RES_BITS-1:0] cur_mask  = bit_mask(bit_q);
  wire [RES_BITS-1:0] next_mask = last_bit ? '0 : bit_mask(bit_q - 4'd1);
  // comparator high means the input is above the trial level, so keep the bit
  wire [RES_BITS-1:0] dec_a = (cmp_a_s ? sar_a_q : (sar_a_q & ~cur_mask)) | next_mask;
  wire [RES_BITS-1:0] dec_b = (cmp_b_s ? sar_b_q : (sar_b_q & ~cur_mask)) | next_mask;
  // offset binary from the dac search into two's complement
  wire [RES_BITS-1:0] msb_flip  = bit_mask(4'(RES_BITS-1));

  // conversion state machine
  // a trigger edge seen while converting is dropped without a
  // sign; the host learns of it only by busy staying low
  // the trigger level at the last step picks tracking or power down
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_TRACK:      if (trig_fall) state_d = ST_CONVERT;
      ST_CONVERT:    if (conv_end) state_d = trig_s ? ST_TRACK : ST_POWER_DOWN;
      ST_POWER_DOWN: if (trig_rise) state_d = ST_TRACK;
      default:       state_d = ST_TRACK;                        // unused code recovers
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_TRACK;
      trig_prev_q <= 1'b1;
    end else if (ce) begin
      state_q     <= state_d;
      trig_prev_q <= trig_s;
    end
  end

  // successive approximation: one bit per settle period of the core clock
  // the search starts at mid scale and each step keeps or drops the trial bit
  // and tries the next; the serial clock never reaches this logic, so a host
  // clocking out results cannot disturb the settling of a running conversion
  // limitation: conversion time grows with the settle count written to ctrl
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_cnt_q <= 8'h00;
      bit_q        <= 4'h0;
      sar_a_q      <= '0;
      sar_b_q      <= '0;
    end else if (ce) begin
      if (conv_go) begin
        settle_cnt_q <= settle_cfg_q;
        bit_q        <= 4'(RES_BITS-1);
        sar_a_q      <= msb_flip;
        sar_b_q      <= msb_flip;
      end else if (state_q == ST_CONVERT) begin
        if (step_due) begin
          settle_cnt_q <= settle_cfg_q;
          bit_q        <= last_bit ? 4'h0 : bit_q - 4'd1;
          sar_a_q      <= dec_a;
          sar_b_q      <= dec_b;
        end else begin
          settle_cnt_q <= settle_cnt_q - 8'd1;
        end
      end
    end
  end

  // finished codes wait while a read frame is open so the word stays still
  // under the serial clock; this is what makes the cross-domain read safe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      new_a_q    <= '0;
      new_b_q    <= '0;
      new_pend_q <= 1'b0;
      res_a_q    <= '0;
      res_b_q    <= '0;
    end else if (ce) begin
      if (conv_end) begin
        new_a_q    <= dec_a ^ msb_flip;
        new_b_q    <= dec_b ^ msb_flip;
        new_pend_q <= 1'b1;
      end else if (new_pend_q && cs_n_s) begin
        res_a_q    <= new_a_q;
        res_b_q    <= new_b_q;
        new_pend_q <= 1'b0;
      end
    end
  end

  // pair select latched as busy rises, applied as busy falls
  // switching the mux only at busy fall gives the new pair the whole track
  // phase to settle before the next hold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pair_latch_q <= 1'b0;
      pair_mux_q   <= 1'b0;
    end else if (ce) begin
      if (conv_go) pair_latch_q <= pair_s;
      if (conv_end) pair_mux_q <= pair_latch_q;
    end
  end

  // reference and span follow the pins except while converting;
  // the reserved span code is refused and the last legal span kept
  // freezing them while converting stops a pin change from shifting the
  // range halfway through a search
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_q      <= 1'b1;
      span_q     <= SPAN_PM10;
      bad_span_q <= 1'b0;
    end else if (ce && state_q != ST_CONVERT) begin
      ref_q      <= ref_s;
      bad_span_q <= (span_s == SPAN_RESERVD);
      if (span_s != SPAN_RESERVD) span_q <= span_s;
    end
  end

  assign busy              = (state_q == ST_CONVERT);
  assign hold              = (state_q == ST_CONVERT);
  assign analog_power_down = (state_q == ST_POWER_DOWN);
  assign dac_a             = sar_a_q;
  assign dac_b             = sar_b_q;
  assign pair_mux_sel      = pair_mux_q;
  assign ref_internal      = ref_q;
  assign span_code         = span_q;

  // wishbone slave: ack one cycle after the request, zero data off the map
  // ack_q also masks the request in its own cycle, so a master that keeps stb
  // up one cycle too long is not answered twice; writes to status or result
  // are acknowledged and dropped
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        hit_ctrl = (wb_adr_i == ADDR_CTRL);
  wire [31:0] status_w = {24'h00_0000, busy, bad_span_q, pair_mux_q, span_q, ref_q,
                          analog_power_down, busy} & 32'h0000_00FF;
  wire [31:0] result_w = {2'b00, res_b_q, 2'b00, res_a_q};
  wire [31:0] ctrl_w   = {24'h00_0000, settle_cfg_q};
  wire [31:0] rd_w     = hit_ctrl                  ? ctrl_w   :
                         (wb_adr_i == ADDR_STATUS) ? status_w :
                         (wb_adr_i == ADDR_RESULT) ? result_w : DATA_ZERO;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q        <= 1'b0;
      wb_dat_o     <= DATA_ZERO;
      settle_cfg_q <= 8'(SETTLE_DEFAULT);
    end else if (ce) begin
      ack_q    <= wb_req;
      wb_dat_o <= wb_req ? rd_w : DATA_ZERO;
      // floor keeps the comparator synchroniser lag inside one step
      if (wb_req && wb_we_i && hit_ctrl && wb_sel_i[0])
        settle_cfg_q <= (wb_dat_i[7:0] < 8'(SYNC_MIN)) ? 8'(SYNC_MIN) : wb_dat_i[7:0];
    end
  end
  assign wb_ack_o = ack_q;

  // serial domain: chip select high ends the frame asynchronously, so no edge
  // is needed after the last bit; a bit is shifted out on each rising edge
  // the word is read straight from core registers; it is safe only because
  // new codes wait in new_a_q and new_b_q until chip select is seen high, so
  // a frame opened within one core cycle of busy falling may mix codes
  wire        frame_rst = rst | chip_select_n;
  logic [4:0] sbit_q;
  logic       out_a_q, out_b_q;
  wire [FRAME_BITS-1:0] word_a = {res_a_q, res_b_q};  // first pin: converter a then b
  wire [FRAME_BITS-1:0] word_b = {res_b_q, res_a_q};  // second pin: b then a
  wire        in_frame = (sbit_q < 5'(FRAME_BITS));
  wire [4:0]  sidx     = 5'(FRAME_BITS-1) - sbit_q;

  always_ff @(posedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      sbit_q  <= 5'h00;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= in_frame ? word_a[sidx] : 1'b0;
      out_b_q <= in_frame ? word_b[sidx] : 1'b0;
      if (in_frame) sbit_q <= sbit_q + 5'h01;
    end
  end

  // pins drive only while chip select is low, never released by the bit count
  // from the 29th edge the pins show zero until the host raises chip select
  // a host that forgets to raise chip select keeps both pins driven
  assign result_out_first     = out_a_q;
  assign result_out_second    = out_b_q;
  assign result_out_first_oe  = ~chip_select_n;
  assign result_out_second_oe = ~chip_select_n;
endmodule

/* tb/sar_ctl_assertions.sv */
// port-level checks for the dual converter sequencer
// assumes ce held high and the default settle count of 3 per bit
module sar_ctl_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic conversion_trigger_n,
  input wire logic chip_select_n,
  input wire logic busy,
  input wire logic hold,
  input wire logic analog_power_down,
  input wire logic result_out_first_oe,
  input wire logic result_out_second_oe,
  input wire logic result_out_first,
  input wire logic result_out_second
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // both stages must switch with busy, and hold only after the trigger went low
  property p_hold; hold == busy && (!$rose(hold) || !$past(conversion_trigger_n)); endproperty
  a_hold: assert property (p_hold) else $error("hold differs from busy");
  property p_start;
    $fell(conversion_trigger_n) && !busy && !analog_power_down |-> ##[1:4] busy;
  endproperty
  a_start: assert property (p_start) else $error("no start after trigger");
  // 14 bits at 4 cycles each
  property p_len; $rose(busy) |-> (busy throughout ##55 1) ##1 !busy; endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_pd; $fell(busy) && !conversion_trigger_n |-> ##[0:1] analog_power_down; endproperty
  a_pd: assert property (p_pd) else $error("no power down");
  property p_pd_off; $fell(busy) && conversion_trigger_n |-> !analog_power_down[*2]; endproperty
  a_pd_off: assert property (p_pd_off) else $error("unwanted power down");
  property p_wake;
    $rose(conversion_trigger_n) && analog_power_down |-> ##[1:6] !analog_power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake up");
  property p_pd_idle; analog_power_down |-> !busy; endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("busy while powered down");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_oe;
    result_out_first_oe == !chip_select_n && result_out_second_oe == !chip_select_n &&
      (!chip_select_n || (!result_out_first && !result_out_second));
  endproperty
  a_oe: assert property (p_oe) else $error("output enable not from select");
  c_conv: cover property ($fell(busy));
  c_pd: cover property ($rose(analog_power_down));
  c_ack: cover property (wb_ack_o);
endmodule

bind dual_sar_conversion_control sar_ctl_checker i_chk (.core_clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .conversion_trigger_n, .chip_select_n, .busy, .hold,
  .analog_power_down, .result_out_first_oe, .result_out_second_oe, .result_out_first,
  .result_out_second);

/* tb/analog_front_model.sv */
// behavioural comparators, two selectable inputs per converter
// assumes hold high freezes the sampled inputs for the whole conversion
module analog_front_model (
  input  wire logic [13:0] vin_a [2],
  input  wire logic [13:0] vin_b [2],
  input  wire logic        pair_mux_sel,
  input  wire logic        hold,
  input  wire logic [13:0] dac_a,
  input  wire logic [13:0] dac_b,
  output logic             comp_a,
  output logic             comp_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] held_a = '0;
  logic [13:0] held_b = '0;
  // sample the selected pair as hold rises; tracking stops here
  always @(posedge hold) begin
    held_a = vin_a[pair_mux_sel];
    held_b = vin_b[pair_mux_sel];
  end
  // inputs sit half a code above their value, so a tie reads as above
  assign comp_a = held_a >= dac_a;
  assign comp_b = held_b >= dac_b;
endmodule

/* tb/dual_sar_conversion_control_tb.sv */
// self-checking bench for the dual converter sequencer
// assumes the comparator model and checker files are compiled before it
module dual_sar_conversion_control_tb import sar_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, ce = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic wb_ack_o, busy, hold, analog_power_down, pair_mux_sel, ref_internal;
  logic conversion_trigger_n = 1, reference_source_select = 1, pair_select = 0;
  logic input_span_sel_lo = 0, input_span_sel_hi = 0, serial_clk = 0, chip_select_n = 1;
  logic comp_a, comp_b, result_out_first, result_out_first_oe;
  logic result_out_second, result_out_second_oe;
  logic [13:0] dac_a, dac_b;
  logic [1:0] span_code;
  logic [13:0] vin_a [2] = '{14'h1234, 14'h3FFF};
  logic [13:0] vin_b [2] = '{14'h0F0F, 14'h0000};
  int num_errors = 0, checked = 0, cycles = 0;

  always #10 core_clk = ~core_clk;

  dual_sar_conversion_control i_dut (.core_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .conversion_trigger_n, .reference_source_select, .input_span_sel_lo,
    .input_span_sel_hi, .pair_select, .busy, .serial_clk, .chip_select_n,
    .result_out_first, .result_out_first_oe, .result_out_second,
    .result_out_second_oe, .comp_a, .comp_b, .dac_a, .dac_b, .hold,
    .analog_power_down, .pair_mux_sel, .ref_internal, .span_code);
  analog_front_model i_afe (.vin_a, .vin_b, .pair_mux_sel, .hold, .dac_a, .dac_b,
    .comp_a, .comp_b);

  task chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    $display("errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one classic cycle; held until ack is sampled high
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task t_regs;
    wb(0, ADDR_CTRL, 0);
    chk(rd[7:0], 8'h03);
    wb(1, ADDR_CTRL, 32'h0000_0001);
    wb(0, ADDR_CTRL, 0);
    chk(rd[7:0], 8'h03);
    wb(0, 4'hC, 0);
    chk(rd, 32'h0000_0000);
    wb(0, ADDR_STATUS, 0);
    chk(rd[7:0], 8'h04);
  endtask

  task t_span;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {input_span_sel_hi, input_span_sel_lo} <= i[1:0];
      repeat (5) @(posedge core_clk);
      chk(span_code, (i == 3) ? 2 : i);
    end
    wb(0, ADDR_STATUS, 0);
    chk(rd[6], 1);
    reference_source_select <= 0;
    {input_span_sel_hi, input_span_sel_lo} <= 2'b00;
    repeat (5) @(posedge core_clk);
    chk(ref_internal, 0);
    reference_source_select <= 1;
  endtask

  // low keeps the trigger down past busy falling
  task t_conv(input logic [13:0] ea, eb, input logic low);
    @(posedge core_clk);
    conversion_trigger_n <= 0;
    for (int i = 0; i < 8 && busy !== 1'b1; i++) @(posedge core_clk);
    chk(hold, 1);
    conversion_trigger_n <= !low;
    for (int i = 0; i < 80 && busy !== 1'b0; i++) @(posedge core_clk);
    chk(hold, 0);
    chk(dac_a, ea);
    chk(dac_b, eb);
    repeat (6) @(posedge core_clk);
    chk(analog_power_down, low);
    wb(0, ADDR_RESULT, 0);
    chk(rd, {2'b00, eb ^ 14'h2000, 2'b00, ea ^ 14'h2000});
    if (low) begin
      conversion_trigger_n <= 1;
      repeat (6) @(posedge core_clk);
      chk(analog_power_down, 0);
    end
  endtask

  // serial clock only runs inside the frame
  task t_serial(input logic [27:0] ea, eb);
    logic [27:0] ga, gb;
    @(posedge core_clk);
    chip_select_n <= 0;
    #37;
    for (int i = 0; i < 28; i++) begin
      serial_clk = 1;
      #62.5;
      ga = {ga[26:0], result_out_first};
      gb = {gb[26:0], result_out_second};
      serial_clk = 0;
      #62.5;
    end
    chk(ga, ea);
    chk(gb, eb);
    chk(result_out_first_oe, 1);
    @(posedge core_clk);
    chip_select_n <= 1;
    @(posedge core_clk);
    chk(result_out_second_oe, 0);
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      results;
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    t_regs;
    t_span;
    pair_select <= 1;
    chk(pair_mux_sel, 0);
    t_conv(vin_a[0], vin_b[0], 0);
    chk(pair_mux_sel, 1);
    t_conv(vin_a[1], vin_b[1], 0);
    t_serial({14'h1FFF, 14'h2000}, {14'h2000, 14'h1FFF});
    t_conv(vin_a[1], vin_b[1], 1);
    results;
  end
endmodule
